// file: core/tcp_defines.svh
// Constants for the three-cell pack protection logic
// ----------------------------------------------------------------------------
// Summary of operation
// - Start in power-down; leave on charger present
// - Overcharge past delay asserts charge inhibit
// - Release flag drops charge inhibit at once
// - Overdischarge past delay turns discharge gate off
// - Overdischarge release flag restores discharge once the charger has left power-down
// - Normal mode: overcurrent past delay gates discharge off
// - Overcurrent trip holds discharge off 256 ms
// - After hold, resume only when load released
// - Three overcurrent levels, each own delay
// - Level two 4 ms, level three 300 us fixed
// - Overcharge, overdischarge delays: 11.8 ms per unit
// - Bleed each overcharged cell until its release
// - Overdischarge trip enters power-down, timers stopped
// - Power-down keeps overcharge detection for overcharged cells
// - Charger in power-down restarts all, normal mode
// - Charging seen through charger comparator flag
// - Charge inhibit active only under overcharge
// - Overdischarge never asserts charge inhibit
// - Sense flags: overcurrent in normal, charger in power-down
// - Hysteresis and levels live in comparators outside
// ----------------------------------------------------------------------------
`ifndef TCP_DEFINES_SVH
`define TCP_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define TCP_CLK_NS 20
`define TCP_TICK_NS 100000
`define TCP_TICK_CYCLES ((`TCP_TICK_NS + `TCP_CLK_NS - 1) / `TCP_CLK_NS)
`define TCP_TICK_US (`TCP_TICK_NS / 1000)
`define TCP_UNIT_US 11800
`define TCP_UNIT_TICKS (`TCP_UNIT_US / `TCP_TICK_US)
`define TCP_OC2_US 4000
`define TCP_OC2_TICKS (`TCP_OC2_US / `TCP_TICK_US)
`define TCP_OC3_US 300
`define TCP_OC3_TICKS (`TCP_OC3_US / `TCP_TICK_US)
`define TCP_HOLD_US 256000
`define TCP_HOLD_TICKS ((`TCP_HOLD_US + `TCP_TICK_US - 1) / `TCP_TICK_US)

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define TCP_OVERVOLT_DELAY_ADDR 12'h000
`define TCP_UNDERVOLT_DELAY_ADDR 12'h004
`define TCP_OVERAMP_DELAY_ADDR 12'h008
`define TCP_STATUS_ADDR 12'h00c
`define TCP_OVERVOLT_DELAY_RST 8'h02
`define TCP_UNDERVOLT_DELAY_RST 8'h02
`define TCP_OVERAMP_DELAY_RST 16'h0096

`endif

// file: core/tcp_pkg.sv
// Types shared by the pack protection logic
package tcp_pkg;
    typedef enum logic [1:0] {
        TCP_MODE_PD = 2'b00,
        TCP_MODE_NORMAL = 2'b01,
        TCP_MODE_OC_HOLD = 2'b10,
        TCP_MODE_OC_WAIT = 2'b11
    } tcp_mode_t;

    // Index 0 is the top cell, 2 the low cell
    typedef struct packed {
        logic [2:0] overvolt;
        logic [2:0] overvolt_release;
        logic [2:0] undervolt;
        logic [2:0] undervolt_release;
        logic [2:0] overamp_level;
        logic charger;
        logic load_released;
    } tcp_flags_t;
endpackage

// file: core/tcp_protect.sv
// Protection decision logic with APB register access
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "tcp_defines.svh"

module tcp_protect #(
    parameter int TICK_CYCLES = `TCP_TICK_CYCLES
)(
    input wire logic clk,
    input wire logic rstn,
    input wire tcp_pkg::tcp_flags_t sense_in,
    output logic charge_inhibit_out,
    output logic discharge_gate_out,
    output logic bleed_cell_top,
    output logic bleed_cell_mid,
    output logic bleed_cell_low,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    tcp_pkg::tcp_flags_t sync1_q;
    tcp_pkg::tcp_flags_t flags_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_q <= '0;
            flags_q <= '0;
        end
        else
        begin
            sync1_q <= sense_in;
            flags_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------------------
    // Common tick
    // ------------------------------------------------------------------------
    logic [15:0] presc_q;
    logic tick_q;

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            presc_q <= 16'h0000;
            tick_q <= 1'b0;
        end
        else if (presc_q >= 16'(TICK_CYCLES - 1))
        begin
            presc_q <= 16'h0000;
            tick_q <= 1'b1;
        end
        else
        begin
            presc_q <= presc_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    logic [7:0] ov_set_q;
    logic [7:0] uv_set_q;
    logic [15:0] oa_set_q;
    tcp_pkg::tcp_mode_t mode_q;
    logic [2:0] ov_cell_q;
    logic [2:0] uv_cell_q;
    logic wr_go;
    logic addr_ok;

    // A request completes on the edge where pready is seen high
    assign wr_go = psel && penable && pready && pwrite;
    assign addr_ok = (paddr == `TCP_OVERVOLT_DELAY_ADDR) ||
        (paddr == `TCP_UNDERVOLT_DELAY_ADDR) || (paddr == `TCP_OVERAMP_DELAY_ADDR) ||
        (paddr == `TCP_STATUS_ADDR);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            ov_set_q <= `TCP_OVERVOLT_DELAY_RST;
            uv_set_q <= `TCP_UNDERVOLT_DELAY_RST;
            oa_set_q <= `TCP_OVERAMP_DELAY_RST;
        end
        else if (wr_go)
        begin
            if (paddr == `TCP_OVERVOLT_DELAY_ADDR)
                ov_set_q <= pwdata[7:0];
            if (paddr == `TCP_UNDERVOLT_DELAY_ADDR)
                uv_set_q <= pwdata[7:0];
            if (paddr == `TCP_OVERAMP_DELAY_ADDR)
                oa_set_q <= pwdata[15:0];
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else if (psel && penable && !pready)
        begin
            pready <= 1'b1;
            pslverr <= !addr_ok;
            case (paddr)
                `TCP_OVERVOLT_DELAY_ADDR: prdata <= {24'h000000, ov_set_q};
                `TCP_UNDERVOLT_DELAY_ADDR: prdata <= {24'h000000, uv_set_q};
                `TCP_OVERAMP_DELAY_ADDR: prdata <= {16'h0000, oa_set_q};
                `TCP_STATUS_ADDR: prdata <= {16'h0000, 3'h0, charge_inhibit_out,
                    discharge_gate_out, bleed_cell_top, bleed_cell_mid, bleed_cell_low,
                    uv_cell_q, ov_cell_q, mode_q};
                default: prdata <= 32'h0000_0000;
            endcase
        end
        else
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Overcharge per cell
    // ------------------------------------------------------------------------
    // A zero setting still waits one tick so a flag glitch cannot trip
    logic [15:0] ov_lim;
    logic [15:0] uv_lim;
    logic [2:0] ov_keep_q;
    logic [2:0] ov_trip;
    logic in_pd;

    assign in_pd = (mode_q == tcp_pkg::TCP_MODE_PD);
    assign ov_lim = (ov_set_q == 8'h00) ? 16'h0001 :
        16'(ov_set_q * 16'(`TCP_UNIT_TICKS));
    assign uv_lim = (uv_set_q == 8'h00) ? 16'h0001 :
        16'(uv_set_q * 16'(`TCP_UNIT_TICKS));

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++)
        begin : g_cell
            logic [15:0] cnt_q;
            logic en;

            assign en = !in_pd || ov_keep_q[gi];
            assign ov_trip[gi] = en && flags_q.overvolt[gi] && (cnt_q >= ov_lim);

            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    cnt_q <= 16'h0000;
                else if (!en || !flags_q.overvolt[gi])
                    cnt_q <= 16'h0000;
                else if (tick_q && cnt_q < ov_lim)
                    cnt_q <= cnt_q + 16'h0001;
            end

            // Set wins over a release seen in the same cycle
            always_ff @(posedge clk or negedge rstn)
            begin
                if (!rstn)
                    ov_cell_q[gi] <= 1'b0;
                else if (ov_trip[gi])
                    ov_cell_q[gi] <= 1'b1;
                else if (flags_q.overvolt_release[gi])
                    ov_cell_q[gi] <= 1'b0;
            end
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Overdischarge timer
    // ------------------------------------------------------------------------
    logic [15:0] uv_cnt_q;
    logic uv_trip;

    assign uv_trip = !in_pd && (|flags_q.undervolt) && (uv_cnt_q >= uv_lim);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            uv_cnt_q <= 16'h0000;
        else if (in_pd || !(|flags_q.undervolt))
            uv_cnt_q <= 16'h0000;
        else if (tick_q && uv_cnt_q < uv_lim)
            uv_cnt_q <= uv_cnt_q + 16'h0001;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            uv_cell_q <= 3'h0;
        else if (uv_trip)
            uv_cell_q <= uv_cell_q | flags_q.undervolt;
        else
            uv_cell_q <= uv_cell_q & ~flags_q.undervolt_release;
    end

    // ------------------------------------------------------------------------
    // Overcurrent timers and mode
    // ------------------------------------------------------------------------
    logic [15:0] oa_lim;
    logic [15:0] oa_cnt_q;
    logic [15:0] hold_cnt_q;
    logic oa_any;
    logic oa_trip;

    // Highest exceeded level picks its own delay; levels two and three are fixed
    assign oa_lim = flags_q.overamp_level[2] ? 16'(`TCP_OC3_TICKS) :
        flags_q.overamp_level[1] ? 16'(`TCP_OC2_TICKS) :
        (oa_set_q == 16'h0000) ? 16'h0001 : oa_set_q;
    assign oa_any = (mode_q == tcp_pkg::TCP_MODE_NORMAL) && (|flags_q.overamp_level);
    assign oa_trip = oa_any && (oa_cnt_q >= oa_lim);

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            oa_cnt_q <= 16'h0000;
        else if (!oa_any)
            oa_cnt_q <= 16'h0000;
        else if (tick_q && oa_cnt_q < oa_lim)
            oa_cnt_q <= oa_cnt_q + 16'h0001;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            hold_cnt_q <= 16'h0000;
        else if (mode_q != tcp_pkg::TCP_MODE_OC_HOLD)
            hold_cnt_q <= 16'h0000;
        else if (tick_q)
            hold_cnt_q <= hold_cnt_q + 16'h0001;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            mode_q <= tcp_pkg::TCP_MODE_PD;
            ov_keep_q <= 3'h0;
        end
        else if (uv_trip)
        begin
            mode_q <= tcp_pkg::TCP_MODE_PD;
            ov_keep_q <= ov_cell_q | ov_trip;
        end
        else
        begin
            case (mode_q)
                tcp_pkg::TCP_MODE_PD:
                    if (flags_q.charger)
                    begin
                        mode_q <= tcp_pkg::TCP_MODE_NORMAL;
                        ov_keep_q <= 3'h0;
                    end
                tcp_pkg::TCP_MODE_NORMAL:
                    if (oa_trip)
                        mode_q <= tcp_pkg::TCP_MODE_OC_HOLD;
                // One extra tick: the first tick after entry may come at once
                tcp_pkg::TCP_MODE_OC_HOLD:
                    if (tick_q && hold_cnt_q >= 16'(`TCP_HOLD_TICKS))
                        mode_q <= tcp_pkg::TCP_MODE_OC_WAIT;
                tcp_pkg::TCP_MODE_OC_WAIT:
                    if (flags_q.load_released)
                        mode_q <= tcp_pkg::TCP_MODE_NORMAL;
                default:
                    mode_q <= tcp_pkg::TCP_MODE_PD;
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    // Overdischarge state never reaches charge inhibit, so charging stays open
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            charge_inhibit_out <= 1'b0;
            discharge_gate_out <= 1'b0;
            bleed_cell_top <= 1'b0;
            bleed_cell_mid <= 1'b0;
            bleed_cell_low <= 1'b0;
        end
        else
        begin
            charge_inhibit_out <= |ov_cell_q;
            discharge_gate_out <= (mode_q == tcp_pkg::TCP_MODE_NORMAL) &&
                !(|uv_cell_q);
            bleed_cell_top <= ov_cell_q[0];
            bleed_cell_mid <= ov_cell_q[1];
            bleed_cell_low <= ov_cell_q[2];
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    pd_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (in_pd && !flags_q.charger && !uv_trip) |=> in_pd)
        else $error("left power-down without charger");

    pd_wake_a: assert property (@(posedge clk) disable iff (!rstn)
        (in_pd && flags_q.charger) |=> (mode_q == tcp_pkg::TCP_MODE_NORMAL))
        else $error("charger did not wake the block");

    ov_release_a: assert property (@(posedge clk) disable iff (!rstn)
        ((|ov_cell_q) && ((ov_cell_q & ~flags_q.overvolt_release) == 3'h0) && !(|ov_trip))
        |=> ##1 !charge_inhibit_out)
        else $error("charge inhibit not released");

    ov_trip_a: assert property (@(posedge clk) disable iff (!rstn)
        (|ov_trip) |=> ##1 (charge_inhibit_out && (bleed_cell_top || bleed_cell_mid ||
        bleed_cell_low)))
        else $error("overcharge trip missed output");

    uv_only_a: assert property (@(posedge clk) disable iff (!rstn)
        (ov_cell_q == 3'h0 && |uv_cell_q) |=> !charge_inhibit_out)
        else $error("overdischarge asserted charge inhibit");

    uv_powerdown_a: assert property (@(posedge clk) disable iff (!rstn)
        uv_trip |=> (in_pd && |uv_cell_q) ##1 !discharge_gate_out)
        else $error("overdischarge did not power down");

    oc_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        (mode_q == tcp_pkg::TCP_MODE_OC_HOLD && hold_cnt_q < 16'(`TCP_HOLD_TICKS))
        |=> (mode_q != tcp_pkg::TCP_MODE_NORMAL) ##1 !discharge_gate_out)
        else $error("overcurrent hold cut short");

    oc_wait_a: assert property (@(posedge clk) disable iff (!rstn)
        (mode_q == tcp_pkg::TCP_MODE_OC_WAIT && !flags_q.load_released && !uv_trip)
        |=> (mode_q == tcp_pkg::TCP_MODE_OC_WAIT))
        else $error("resumed before load release");

    oc_third_a: assert property (@(posedge clk) disable iff (!rstn)
        (oa_any && flags_q.overamp_level[2] && oa_cnt_q >= 16'(`TCP_OC3_TICKS) && !uv_trip)
        |=> (mode_q == tcp_pkg::TCP_MODE_OC_HOLD))
        else $error("level three delay wrong");

    oc_restart_a: assert property (@(posedge clk) disable iff (!rstn)
        !oa_any |=> (oa_cnt_q == 16'h0000))
        else $error("overcurrent timer not restarted");

endmodule // tcp_protect

// file: verif/tb_tcp_protect.sv
// Self-checking bench for the pack protection logic
`timescale 1ns/100ps
module tb_tcp_protect;
    localparam int TK = 4;
    localparam int UNIT = 118 * TK;
    localparam int HOLD = 2560 * TK;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, inh, gate, b_top, b_mid, b_low, ch_on, dis_on, load_rel;
    logic load_present = 1'b1;
    logic [7:0] lag = 8'h00;
    tcp_pkg::tcp_flags_t fl;
    tcp_pkg::tcp_flags_t sense;
    logic [32:0] expq[$];
    logic [32:0] e;
    logic [31:0] seed = 32'hc54e;
    logic [31:0] st;
    logic [4:0] m;
    int n_fail = 0;
    int compares = 0;
    int n, a, b, c, lim, lim1;
    always #10 clk = ~clk;
    always_comb
    begin
        sense = fl;
        sense.load_released = load_rel;
    end
    tcp_protect #(.TICK_CYCLES(TK)) u_tcp_protect (.clk(clk), .rstn(rstn), .sense_in(sense),
        .charge_inhibit_out(inh), .discharge_gate_out(gate), .bleed_cell_top(b_top),
        .bleed_cell_mid(b_mid), .bleed_cell_low(b_low), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));
    tcp_switch_model u_tcp_switch_model (.clk(clk), .lag(lag), .charge_inhibit_out(inh),
        .discharge_gate_out(gate), .load_present(load_present), .charge_on(ch_on),
        .discharge_on(dis_on), .load_released(load_rel));
    // ------
    // Helpers
    // ------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [4:0] outs();
        return {b_low, b_mid, b_top, gate, inh};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic span(input string what, input int v, input int lo, input int hi);
        check(what, 32'(v >= lo && v <= hi), 32'h1);
    endtask
    task automatic wait_for(input int w, input logic v, input int lmt, output int cnt);
        logic [4:0] o;
        cnt = 0;
        o = outs();
        while (o[w] !== v && cnt < lmt)
        begin
            @(posedge clk);
            cnt++;
            o = outs();
        end
    endtask
    // Expected answer is queued here, compared by the monitor below
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd,
        input logic [32:0] exp);
        expq.push_back(exp);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        penable <= 1'b0;
        @(posedge clk);
        penable <= 1'b1;
        // No cycle count assumed: only the watchdog ends a stuck transfer
        do
            @(posedge clk);
        while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    always @(posedge clk)
        if (psel && penable && pready === 1'b1 && expq.size() > 0)
        begin
            e = expq.pop_front();
            check("pslverr", 32'(pslverr), 32'(e[32]));
            if (!pwrite)
                check("prdata", prdata, e[31:0]);
        end
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #1600000;
        n_fail++;
        $display("Watchdog expired");
        print_verdict();
    end
    // ------
    // Main sequence
    // ------
    initial
    begin
        fl = '0;
        fl.overvolt_release = 3'b111;
        fl.undervolt_release = 3'b111;
        fl.overamp_level = 3'b111;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (50) @(posedge clk);
        check("power-up outputs", 32'(outs()), 32'h0);
        lim1 = 10 + int'(rnd() % 30);
        apb(1'b1, 12'h00c, 32'hffff_ffff, 33'h0);
        apb(1'b0, 12'h00c, 32'h0, 33'h0);
        apb(1'b0, 12'h000, 32'h0, 33'h2);
        apb(1'b0, 12'h004, 32'h0, 33'h2);
        apb(1'b0, 12'h008, 32'h0, 33'h96);
        apb(1'b1, 12'h010, 32'h1, {1'b1, 32'h0});
        apb(1'b1, 12'h000, 32'h1, 33'h0);
        apb(1'b1, 12'h004, 32'h1, 33'h0);
        apb(1'b1, 12'h008, 32'(lim1), 33'h0);
        apb(1'b0, 12'h008, 32'h0, {1'b0, 32'(lim1)});
        fl.overamp_level <= 3'b000;
        repeat (10) @(posedge clk);
        fl.charger <= 1'b1;
        wait_for(1, 1'b1, 20, n);
        check("wake gate", 32'(outs()), 32'h2);
        fl.charger <= 1'b0;
        apb(1'b0, 12'h00c, 32'h0, 33'h801);
        $display("Test power-up and wake done");
        a = int'(rnd() % 3);
        fl.overvolt[a] <= 1'b1;
        fl.overvolt_release[a] <= 1'b0;
        repeat (UNIT / 2) @(posedge clk);
        fl.overvolt[a] <= 1'b0;
        repeat (10) @(posedge clk);
        fl.overvolt[a] <= 1'b1;
        wait_for(0, 1'b1, UNIT + 40, n);
        span("overcharge delay", n, UNIT - TK - 2, UNIT + TK + 8);
        check("overcharge outputs", 32'(outs()), 32'(5'h4 << a) | 32'h3);
        check("charge switch", 32'(ch_on), 32'h0);
        fl.overvolt[a] <= 1'b0;
        fl.overvolt_release[a] <= 1'b1;
        wait_for(0, 1'b0, 8, n);
        check("overcharge release", 32'(outs()), 32'h2);
        $display("Test overcharge done");
        for (int lv = 0; lv < 3; lv++)
        begin
            lim = (lv == 0) ? lim1 * TK : (lv == 1) ? 40 * TK : 3 * TK;
            lag <= 8'(lv * 12);
            fl.overamp_level <= (lv == 2) ? 3'b111 : (lv == 1) ? 3'b011 : 3'b001;
            wait_for(1, 1'b0, lim + 40, n);
            span("overcurrent delay", n, lim - TK - 2, lim + TK + 8);
            fl.overamp_level <= 3'b000;
            load_present <= (lv == 2);
            wait_for(1, 1'b1, HOLD + 40, n);
            if (lv == 2)
            begin
                check("load still on", 32'(outs()), 32'h0);
                load_present <= 1'b0;
                wait_for(1, 1'b1, 40, n);
            end
            else
                span("overcurrent hold", n, HOLD, HOLD + TK + 12);
            check("gate back", 32'(outs()), 32'h2);
            load_present <= 1'b1;
            repeat (40) @(posedge clk);
        end
        $display("Test overcurrent done");
        for (int p = 0; p < 2; p++)
        begin
            a = int'(rnd() % 3);
            b = (a + 1) % 3;
            c = (a + 2) % 3;
            m = (p == 0) ? (5'h4 << a) | 5'h1 : 5'h0;
            st = (32'h20 << b) | ((p == 0) ? (32'h4 << a) | (32'h400 >> a) | 32'h1000 : 32'h0);
            if (p == 0)
            begin
                fl.overvolt[a] <= 1'b1;
                fl.overvolt_release[a] <= 1'b0;
                wait_for(0, 1'b1, UNIT + 40, n);
            end
            fl.undervolt[b] <= 1'b1;
            fl.undervolt_release[b] <= 1'b0;
            wait_for(1, 1'b0, UNIT + 40, n);
            span("overdischarge delay", n, UNIT - TK - 2, UNIT + TK + 8);
            apb(1'b0, 12'h00c, 32'h0, {1'b0, st});
            fl.overvolt[c] <= 1'b1;
            repeat (UNIT + 40) @(posedge clk);
            check("power-down outputs", 32'(outs()), 32'(m));
            fl.overvolt[c] <= 1'b0;
            fl.overvolt[a] <= 1'b0;
            fl.overvolt_release[a] <= 1'b1;
            wait_for(0, 1'b0, 8, n);
            check("power-down release", 32'(outs()), 32'h0);
            fl.undervolt[b] <= 1'b0;
            fl.charger <= 1'b1;
            repeat (20) @(posedge clk);
            check("latch holds gate", 32'(outs()), 32'h0);
            fl.charger <= 1'b0;
            fl.undervolt_release[b] <= 1'b1;
            wait_for(1, 1'b1, 10, n);
            check("discharge back", 32'(outs()), 32'h2);
        end
        $display("Test overdischarge done");
        repeat (5) @(posedge clk);
        check("apb queue", 32'(expq.size()), 32'h0);
        print_verdict();
    end
endmodule // tb_tcp_protect

// file: verif/tcp_switch_model.sv
// Model of the external charge and discharge switches and the pack terminals
`timescale 1ns/100ps
module tcp_switch_model (
    input wire logic clk,
    input wire logic [7:0] lag,
    input wire logic charge_inhibit_out,
    input wire logic discharge_gate_out,
    input wire logic load_present,
    output logic charge_on,
    output logic discharge_on,
    output logic load_released
);
    logic [7:0] cnt_q = 8'h00;
    logic on_q = 1'b0;
    assign discharge_on = on_q;
    // Gate charge makes the switch follow its drive only after lag clocks
    always @(posedge clk)
    begin
        if (discharge_gate_out === on_q)
            cnt_q <= 8'h00;
        else if (cnt_q >= lag)
        begin
            on_q <= discharge_gate_out;
            cnt_q <= 8'h00;
        end
        else
            cnt_q <= cnt_q + 8'h01;
    end
    assign charge_on = !charge_inhibit_out;
    // Terminals float only with the switch open and the load gone
    assign load_released = !discharge_on && !load_present;
endmodule // tcp_switch_model
